// >>> src/int_status_pkg.sv
// Purpose: Shared constants and carrier types for the common interrupt status block.
// Assumes: Offsets are host byte offsets on a 16-bit host bus; the upper byte sits at the even one.
// Notes:   The register offsets, chip flag bit positions and mask and read data reset values used by the design live here.
package int_status_pkg;

   // Host address width and register offsets
   localparam int          ADDR_W        = 10;
   localparam logic [9:0]  STATUS_OFFSET = 10'h002;
   localparam logic [9:0]  MASK_OFFSET   = 10'h004;

   // Register widths and counts
   localparam int          REG_W         = 16;
   localparam int          CHIP_FLAGS    = 4;
   localparam int          SOCKETS       = 8;

   // Bit positions inside the status and mask registers
   localparam int          ADDR_CONFLICT_BIT = 15;
   localparam int          PORT_UNREACH_BIT  = 14;
   localparam int          SESSION_END_BIT   = 13;
   localparam int          FRAG_SIZE_BIT     = 12;
   localparam int          CHIP_LSB          = 12;

   // Reset values and writable field masks
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] MASK_WRITABLE = 16'hf0ff;
   localparam logic [15:0] READ_IDLE     = 16'h0000;

   // One host access on the direct host bus
   typedef struct packed {
      logic [9:0]  addr;
      logic [15:0] wrData;
      logic        wrEn;
      logic        rdEn;
      logic        beUpper;
      logic        beLower;
   } host_req_t;

   // Chip-wide event pulses from the protocol engines
   typedef struct packed {
      logic addrConflict;
      logic portUnreach;
      logic sessionClosed;
      logic fragSize;
   } chip_evt_t;

endpackage

// >>> src/sticky_flag.sv
// Purpose: One sticky event flag with a set input and a clear input.
// Assumes: Set and clear are single-clock signals from the same domain.
// Notes:   Set beats clear so an event in the clearing cycle is kept.
`timescale 1ns/10ps
module sticky_flag (
   input  wire logic clk,    // System clock
   input  wire logic rst_n,  // Asynchronous reset, active low
   input  wire logic set,    // Event that raises the flag
   input  wire logic clr,    // Request that lowers the flag
   output logic      flag_q  // Registered flag
);

   logic flag_d;

   // Next value, set has priority
   always_comb begin
      flag_d = flag_q;
      if (clr) begin
         flag_d = 1'b0;
      end
      if (set) begin
         flag_d = 1'b1;
      end
   end

   // Flag register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule

// >>> src/common_interrupt_status.sv
// Purpose: Common interrupt status and mask registers with the active-low interrupt pin.
// Assumes: Event inputs come from logic on clk; host accesses are single-cycle strobes.
// Notes:   Read data appear one cycle after the read strobe, marked by rdValid_q.
//
// Operation
// - Any supported event sets its matching status bit to one.
// - The interrupt pin goes low when some status bit and its mask bit are both one.
// - Once low, the pin stays low until all status bits are zero, then goes high.
// - Upper-byte flags clear only where the host writes a one; a zero leaves them.
// - A socket bit clears itself once that socket's interrupt register is all zero.
// - Bit 15 sets when an address request carries our own network address.
// - Bit 14 sets on a destination-port-unreachable message.
// - Bit 13 sets on session close, but only while the session mode is on.
// - Bit 12 sets on a fragmentation-needed message.
// - Lower bit n sets whenever socket n raises any of its own interrupts.
// - The status register is 16 bits, resets to zero, upper byte at the even offset.
// - A 16-bit mask register holds one enable per used status bit (bits 11:8 stay zero) and resets to zero.
`timescale 1ns/10ps
module common_interrupt_status
   import int_status_pkg::*;
(
   input  wire logic         clk,          // System clock, 100 MHz
   input  wire logic         rst_n,        // Asynchronous reset, active low
   input  wire host_req_t    hostReq,      // Host register access
   output logic [15:0]       rdData_q,     // Registered read data
   output logic              rdValid_q,    // Read data valid pulse
   input  wire chip_evt_t    chipEvt,      // Chip-wide event pulses
   input  wire logic         sessionMode,  // Session mode enabled level
   input  wire logic [7:0]   sockEvt,      // Socket n raised an interrupt
   input  wire logic [7:0]   sockIrZero,   // Socket n interrupt register is zero
   output logic              intN_q        // Interrupt pin, active low
);

   logic [3:0]  chipSet;
   logic [3:0]  chipClr;
   logic [3:0]  chipFlagQ;
   logic [7:0]  sockFlagQ;
   logic [15:0] statusQ;
   logic [15:0] maskQ;
   logic [15:0] maskD;
   logic [15:0] rdDataD;
   logic        rdValidD;
   logic        intActiveQ;
   logic        intActiveD;
   logic        statusWr;
   logic        maskWr;

   // Address decode of host writes
   assign statusWr = hostReq.wrEn && (hostReq.addr == STATUS_OFFSET);
   assign maskWr   = hostReq.wrEn && (hostReq.addr == MASK_OFFSET);

   assign chipSet = {chipEvt.addrConflict, chipEvt.portUnreach,
                     chipEvt.sessionClosed & sessionMode, chipEvt.fragSize};

   assign chipClr = (statusWr && hostReq.beUpper) ?
                    hostReq.wrData[ADDR_CONFLICT_BIT:FRAG_SIZE_BIT] : 4'h0;

   generate
      for (genvar i = 0; i < CHIP_FLAGS; i++) begin : g_chip
         sticky_flag u_flag (
            .clk    (clk),
            .rst_n  (rst_n),
            .set    (chipSet[i]),
            .clr    (chipClr[i]),
            .flag_q (chipFlagQ[i])
         );
      end
   endgenerate

   generate
      for (genvar n = 0; n < SOCKETS; n++) begin : g_sock
         sticky_flag u_flag (
            .clk    (clk),
            .rst_n  (rst_n),
            .set    (sockEvt[n]),
            .clr    (sockIrZero[n]),
            .flag_q (sockFlagQ[n])
         );
      end
   endgenerate

   assign statusQ = {chipFlagQ, 4'h0, sockFlagQ};

   always_comb begin
      maskD = maskQ;
      if (maskWr && hostReq.beUpper) begin
         maskD[15:8] = hostReq.wrData[15:8] & MASK_WRITABLE[15:8];
      end
      if (maskWr && hostReq.beLower) begin
         maskD[7:0] = hostReq.wrData[7:0] & MASK_WRITABLE[7:0];
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         maskQ <= MASK_RESET;
      end else begin
         maskQ <= maskD;
      end
   end

   always_comb begin
      intActiveD = (|(statusQ & maskQ)) || (intActiveQ && (|statusQ));
   end

   // Interrupt pin register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intActiveQ <= 1'b0;
         intN_q     <= 1'b1;
      end else begin
         intActiveQ <= intActiveD;
         intN_q     <= !intActiveD;
      end
   end

   // Read decode, unmapped offsets read zero
   always_comb begin
      rdDataD  = rdData_q;
      rdValidD = hostReq.rdEn;
      if (hostReq.rdEn) begin
         unique case (hostReq.addr)
            STATUS_OFFSET: begin
               rdDataD = statusQ;
            end
            MASK_OFFSET: begin
               rdDataD = maskQ;
            end
            default: begin
               rdDataD = READ_IDLE;
            end
         endcase
      end
   end

   // Read data registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q  <= READ_IDLE;
         rdValid_q <= 1'b0;
      end else begin
         rdData_q  <= rdDataD;
         rdValid_q <= rdValidD;
      end
   end

   // Checks on flag setting and socket self-clearing; the pin check uses the mask seen when the pin was computed
   property p_conflict_sets;
      @(posedge clk) disable iff (!rst_n)
      chipEvt.addrConflict |=> statusQ[ADDR_CONFLICT_BIT]
         ##1 (!intN_q || !$past(maskQ[ADDR_CONFLICT_BIT]));
   endproperty
   a_conflict_sets: assert property (p_conflict_sets)
      else $error("conflict flag not set");

   property p_unreach_sets;
      @(posedge clk) disable iff (!rst_n)
      chipEvt.portUnreach |=> statusQ[PORT_UNREACH_BIT];
   endproperty
   a_unreach_sets: assert property (p_unreach_sets)
      else $error("unreach flag not set");

   property p_session_gated;
      @(posedge clk) disable iff (!rst_n)
      (!statusQ[SESSION_END_BIT] && !(chipEvt.sessionClosed && sessionMode))
         |=> !statusQ[SESSION_END_BIT];
   endproperty
   a_session_gated: assert property (p_session_gated)
      else $error("session flag set wrongly");

   property p_session_sets;
      @(posedge clk) disable iff (!rst_n)
      (chipEvt.sessionClosed && sessionMode) |=> statusQ[SESSION_END_BIT];
   endproperty
   a_session_sets: assert property (p_session_sets)
      else $error("session flag not set");

   property p_frag_sets;
      @(posedge clk) disable iff (!rst_n)
      chipEvt.fragSize |=> statusQ[FRAG_SIZE_BIT];
   endproperty
   a_frag_sets: assert property (p_frag_sets)
      else $error("fragment flag not set");

   property p_sock_sets;
      @(posedge clk) disable iff (!rst_n)
      sockEvt[0] |=> sockFlagQ[0];
   endproperty
   a_sock_sets: assert property (p_sock_sets)
      else $error("socket flag not set");

   property p_sock7_sets;
      @(posedge clk) disable iff (!rst_n)
      sockEvt[7] |=> sockFlagQ[7];
   endproperty
   a_sock7_sets: assert property (p_sock7_sets)
      else $error("socket seven flag not set");

   property p_sock_clears;
      @(posedge clk) disable iff (!rst_n)
      (sockIrZero[7] && !sockEvt[7]) |=> !sockFlagQ[7];
   endproperty
   a_sock_clears: assert property (p_sock_clears)
      else $error("socket flag not cleared");

   property p_sock0_clears;
      @(posedge clk) disable iff (!rst_n)
      (sockIrZero[0] && !sockEvt[0]) |=> !sockFlagQ[0];
   endproperty
   a_sock0_clears: assert property (p_sock0_clears)
      else $error("socket zero flag not cleared");

   // Socket bits have no host write path
   property p_sock_no_write;
      @(posedge clk) disable iff (!rst_n)
      (statusWr && hostReq.beLower && sockFlagQ[0] && !sockIrZero[0]) |=> sockFlagQ[0];
   endproperty
   a_sock_no_write: assert property (p_sock_no_write)
      else $error("socket flag cleared by write");

   property p_zero_write_keeps;
      @(posedge clk) disable iff (!rst_n)
      (statusWr && hostReq.beUpper && !hostReq.wrData[ADDR_CONFLICT_BIT]
         && statusQ[ADDR_CONFLICT_BIT]) |=> statusQ[ADDR_CONFLICT_BIT];
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps)
      else $error("zero write cleared");

   property p_one_write_clears;
      @(posedge clk) disable iff (!rst_n)
      (statusWr && hostReq.beUpper && hostReq.wrData[PORT_UNREACH_BIT] && !chipEvt.portUnreach)
         |=> !statusQ[PORT_UNREACH_BIT];
   endproperty
   a_one_write_clears: assert property (p_one_write_clears)
      else $error("one write kept");

   // A write with the upper lane off leaves the chip flags alone
   property p_lane_keeps;
      @(posedge clk) disable iff (!rst_n)
      (statusWr && !hostReq.beUpper && statusQ[FRAG_SIZE_BIT]) |=> statusQ[FRAG_SIZE_BIT];
   endproperty
   a_lane_keeps: assert property (p_lane_keeps)
      else $error("disabled lane cleared");

   property p_masked_asserts;
      @(posedge clk) disable iff (!rst_n)
      (|(statusQ & maskQ)) |=> !intN_q;
   endproperty
   a_masked_asserts: assert property (p_masked_asserts)
      else $error("pin not asserted");

   // The pin never falls without a masked pending bit
   property p_unmasked_quiet;
      @(posedge clk) disable iff (!rst_n)
      (intN_q && !(|(statusQ & maskQ))) |=> intN_q;
   endproperty
   a_unmasked_quiet: assert property (p_unmasked_quiet)
      else $error("pin asserted while masked");

   property p_hold_low;
      @(posedge clk) disable iff (!rst_n)
      (!intN_q && (|statusQ)) |=> !intN_q;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("pin released early");

   property p_release;
      @(posedge clk) disable iff (!rst_n)
      (statusQ == STATUS_RESET) |=> intN_q;
   endproperty
   a_release: assert property (p_release)
      else $error("pin not released");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rst_n)
      (rdValid_q && $past(hostReq.addr) == STATUS_OFFSET) |-> (rdData_q[11:8] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits set");

   property p_mask_readback;
      @(posedge clk) disable iff (!rst_n)
      (maskWr && hostReq.beLower) |=> (maskQ[7:0] == $past(hostReq.wrData[7:0]));
   endproperty
   a_mask_readback: assert property (p_mask_readback)
      else $error("mask not written");

   // Upper mask lane takes the four enables and keeps the reserved nibble zero
   property p_mask_upper;
      @(posedge clk) disable iff (!rst_n)
      (maskWr && hostReq.beUpper)
         |=> (maskQ[15:12] == $past(hostReq.wrData[15:12])) && (maskQ[11:8] == 4'h0);
   endproperty
   a_mask_upper: assert property (p_mask_upper)
      else $error("upper mask not written");

   property p_status_read;
      @(posedge clk) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == STATUS_OFFSET)
         |=> (rdValid_q && rdData_q == $past(statusQ));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read wrong");

   // Read valid only follows a read strobe
   property p_valid_pulse;
      @(posedge clk) disable iff (!rst_n)
      !hostReq.rdEn |=> !rdValid_q;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse)
      else $error("read valid without strobe");

endmodule

// >>> bench/host_model.sv
// Purpose: Host processor model that reads and clears the status registers.
// Assumes: Requests change at the falling clock edge and last one clock.
// Notes:   Write data are inverted after release so stale values never linger.
`timescale 1ns/10ps
module host_model
   import int_status_pkg::*;
(
   input  wire logic        clk,       // System clock
   output host_req_t        hostReq,   // Host access
   input  wire logic [15:0] rdData_q,  // Read data
   input  wire logic        rdValid_q  // Read data valid
);
   // Idle bus at start
   initial begin
      hostReq = '0;
   end

   task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] be);
      @(negedge clk);
      hostReq = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0, beUpper: be[1], beLower: be[0]};
      @(negedge clk);
      hostReq.wrEn = 1'b0;
      hostReq.wrData = ~d;  // Released data lines
   endtask

   // One read; data and valid taken one clock later
   task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic v);
      @(negedge clk);
      hostReq.addr = a;
      hostReq.rdEn = 1'b1;
      @(negedge clk);
      hostReq.rdEn = 1'b0;
      d = rdData_q;
      v = rdValid_q;
   endtask
endmodule

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the common interrupt status block.
// Assumes: Inputs change at the falling edge; reset held five clocks.
// Notes:   Socket clear condition is driven directly as a level.
`timescale 1ns/10ps
module testbench
   import int_status_pkg::*;
;
   logic        clk, rst_n, sessionMode, rdValid_q, intN_q;
   host_req_t   hostReq;
   chip_evt_t   chipEvt;
   logic [15:0] rdData_q;
   logic [7:0]  sockEvt, sockIrZero;
   int          err_total, checks_done;

   // Design and host partner
   common_interrupt_status u_common_interrupt_status (.clk(clk), .rst_n(rst_n),
      .hostReq(hostReq), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .chipEvt(chipEvt),
      .sessionMode(sessionMode), .sockEvt(sockEvt), .sockIrZero(sockIrZero), .intN_q(intN_q));
   host_model u_host_model (.clk(clk), .hostReq(hostReq), .rdData_q(rdData_q),
      .rdValid_q(rdValid_q));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      u_host_model.rd(a, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, exp);
   endtask

   task automatic pin(input logic exp);
      chk({15'h0000, intN_q}, {15'h0000, exp});
   endtask

   task automatic evt(input chip_evt_t e, input logic [7:0] s);
      @(negedge clk);
      chipEvt = e;
      sockEvt = s;
      @(negedge clk);
      chipEvt = '0;
      sockEvt = 8'h00;
   endtask

   task automatic t_reset;
      rdchk(STATUS_OFFSET, 16'h0000);
      rdchk(MASK_OFFSET, 16'h0000);
      pin(1'b1);
   endtask

   task automatic t_chip;
      sessionMode = 1'b0;
      evt(4'b0010, 8'h00);
      rdchk(STATUS_OFFSET, 16'h0000);
      sessionMode = 1'b1;
      for (int i = 0; i < 4; i++) begin
         evt(4'b1000 >> i, 8'h00);
         rdchk(STATUS_OFFSET, 16'h8000 >> i);
         pin(1'b1);
         u_host_model.wr(STATUS_OFFSET, 16'h8000 >> i, 2'b10);
         rdchk(STATUS_OFFSET, 16'h0000);
      end
   endtask

   task automatic t_clear;
      evt(4'hf, 8'h00);
      u_host_model.wr(STATUS_OFFSET, 16'h0000, 2'b11);
      rdchk(STATUS_OFFSET, 16'hf000);
      u_host_model.wr(STATUS_OFFSET, 16'hffff, 2'b01);
      rdchk(STATUS_OFFSET, 16'hf000);
      u_host_model.wr(STATUS_OFFSET, 16'h5fff, 2'b11);
      rdchk(STATUS_OFFSET, 16'ha000);
      u_host_model.wr(STATUS_OFFSET, 16'ha000, 2'b10);
      rdchk(STATUS_OFFSET, 16'h0000);
      u_host_model.wr(MASK_OFFSET, 16'hffff, 2'b11);
      rdchk(MASK_OFFSET, 16'hf0ff);
      u_host_model.wr(MASK_OFFSET, 16'h0000, 2'b10);
      rdchk(MASK_OFFSET, 16'h00ff);
      rdchk(10'h006, 16'h0000);
   endtask

   task automatic t_sock;
      u_host_model.wr(MASK_OFFSET, 16'h0000, 2'b11);
      for (int n = 0; n < 8; n++) begin
         evt('0, 8'h01 << n);
         rdchk(STATUS_OFFSET, 16'h0001 << n);
         u_host_model.wr(STATUS_OFFSET, 16'hffff, 2'b11);
         rdchk(STATUS_OFFSET, 16'h0001 << n);
         sockIrZero = 8'h01 << n;
         rdchk(STATUS_OFFSET, 16'h0000);
         sockIrZero = 8'h00;
      end
   endtask

   // Event and clear on one edge: the event must win
   task automatic t_race;
      fork
         evt(4'b1000, 8'h01);
         u_host_model.wr(STATUS_OFFSET, 16'h8000, 2'b10);
         begin
            @(negedge clk);
            sockIrZero = 8'h01;
            @(negedge clk);
            sockIrZero = 8'h00;
         end
      join
      rdchk(STATUS_OFFSET, 16'h8001);
      pin(1'b1);
      u_host_model.wr(STATUS_OFFSET, 16'h8000, 2'b10);
      sockIrZero = 8'h01;
      rdchk(STATUS_OFFSET, 16'h0000);
      sockIrZero = 8'h00;
   endtask

   task automatic t_pin;
      u_host_model.wr(MASK_OFFSET, 16'h1000, 2'b11);
      evt('0, 8'h01);
      @(negedge clk);
      pin(1'b1);
      evt(4'b0001, 8'h00);
      @(negedge clk);
      pin(1'b0);
      u_host_model.wr(MASK_OFFSET, 16'h0000, 2'b11);
      u_host_model.wr(STATUS_OFFSET, 16'h1000, 2'b10);
      @(negedge clk);
      pin(1'b0);
      sockIrZero = 8'h01;
      repeat (2) @(negedge clk);
      pin(1'b1);
      sockIrZero = 8'h00;
   endtask

   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      err_total = 0;
      checks_done = 0;
      rst_n = 1'b0;
      sessionMode = 1'b0;
      chipEvt = '0;
      sockEvt = 8'h00;
      sockIrZero = 8'h00;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_chip();
      t_clear();
      t_sock();
      t_race();
      t_pin();
      results();
   end

   // Watchdog
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule
